// ===== servo_current_loop.v
// Velocity filters, current limiter, current PI loop, PWM and position feedback
`timescale 1ns/10ps
`include "servo_loop_map.vh"

module servo_current_loop #(
  parameter [15:0] RATED_PEAK    = 16'h7fff,
  parameter [15:0] SERVO_PER_MS  = 16'h0010,
  parameter        GAIN_SHIFT    = 14,
  parameter        ACC_FF_SHIFT  = 14,
  parameter        PWM_W         = 12
) (
  input  wire               i_clk,
  input  wire               i_nrst,
  input  wire               i_servo_tick,
  input  wire               i_loop_enable,
  input  wire               i_dual_encoder,
  input  wire [31:0]        i_vel_cmd,
  input  wire [15:0]        i_vel_loop_out,
  input  wire [15:0]        i_current_actual,
  input  wire [31:0]        i_traj_pos,
  input  wire [31:0]        i_traj_vel,
  input  wire [31:0]        i_traj_accel,
  input  wire [1:0]         i_enc_a,
  input  wire [1:0]         i_enc_b,
  input  wire               i_obj_rd,
  input  wire               i_obj_wr,
  input  wire [15:0]        i_obj_index,
  input  wire [7:0]         i_obj_sub,
  input  wire [31:0]        i_obj_wdata,
  output reg  [31:0]        o_obj_rdata,
  output reg                o_obj_ack,
  output reg                o_obj_err,
  output wire [31:0]        o_vel_cmd_filt,
  output reg  [31:0]        o_vel_ff,
  output reg  [31:0]        o_accel_ff,
  output reg  [31:0]        o_pos_actual,
  output reg  [PWM_W-1:0]   o_duty,
  output reg                o_pwm
);

  function [31:0] sat32;
    input [49:0] v;
    begin
      if ((&v[49:31]) || ~(|v[49:31]))
        sat32 = v[31:0];
      else
        sat32 = v[49] ? `S32_MIN : `S32_MAX;
    end
  endfunction

  function [15:0] sat16;
    input [49:0] v;
    begin
      if ((&v[49:15]) || ~(|v[49:15]))
        sat16 = v[15:0];
      else
        sat16 = v[49] ? `S16_MIN : `S16_MAX;
    end
  endfunction

  // Filter configuration, index 0 = command filter, 1 = output filter
  reg  [1:0]         ftype [0:1];
  reg  [15:0]        fb0   [0:1];
  reg  [15:0]        fb1   [0:1];
  reg  [15:0]        fb2   [0:1];
  reg  [15:0]        fa1   [0:1];
  reg  [15:0]        fa2   [0:1];
  wire [31:0]        fout  [0:1];
  wire [31:0]        fin   [0:1];

  reg  [15:0]        peak_lim;
  reg  [15:0]        cont_lim;
  reg  [15:0]        peak_time;
  reg  [15:0]        cur_prop_gain;
  reg  [15:0]        cur_integral_gain;
  reg  [15:0]        vel_ff_gain;
  reg  [15:0]        acc_ff_gain;

  reg  [31:0]        trajectory_velocity_out;
  reg  [31:0]        trajectory_accel_out;
  reg  [31:0]        position_demand;
  reg  [15:0]        cmd_current;
  reg  [15:0]        limited_current;
  reg  [31:0]        integ;
  reg  [31:0]        peak_cnt;
  reg                tick_d1;
  reg                tick_d2;
  reg  [PWM_W-1:0]   pwm_cnt;

  wire [31:0]        enc_cnt [0:1];
  wire               enc_sel = i_dual_encoder;
  reg                pos_load;
  reg  [31:0]        pos_load_val;

  assign fin[0] = i_vel_cmd;
  assign fin[1] = {{16{i_vel_loop_out[15]}}, i_vel_loop_out};
  assign o_vel_cmd_filt = fout[0];

  // Each filter has its own copy of the same second-order datapath
  genvar f;
  generate
    for (f = 0; f < 2; f = f + 1) begin : g_filt
      reg  [31:0] x1, x2, y1, y2, y;
      wire        first = (ftype[f] == `FT_SINGLE);
      // A single pole has no second tap
      wire [15:0] b2e = first ? `ZERO16 : fb2[f];
      wire [15:0] a2e = first ? `ZERO16 : fa2[f];
      wire signed [49:0] acc =
          $signed(fin[f]) * $signed(fb0[f]) + $signed(x1) * $signed(fb1[f])
        + $signed(x2) * $signed(b2e) - $signed(y1) * $signed(fa1[f])
        - $signed(y2) * $signed(a2e);
      wire signed [49:0] acc_sh = acc >>> `COEF_SHIFT;
      wire [31:0] next_y = (ftype[f] == `FT_OFF) ? fin[f] : sat32(acc_sh);
      always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          x1 <= `ZERO32;
          x2 <= `ZERO32;
          y1 <= `ZERO32;
          y2 <= `ZERO32;
          y  <= `ZERO32;
        end else if (i_servo_tick) begin
          x1 <= fin[f];
          x2 <= x1;
          y1 <= next_y;
          y2 <= y1;
          y  <= next_y;
        end
      end
      assign fout[f] = y;
    end
  endgenerate

  // Quadrature counters, index 0 = motor encoder, 1 = load encoder
  genvar e;
  generate
    for (e = 0; e < 2; e = e + 1) begin : g_enc
      reg  [2:0]  sa, sb;
      reg  [1:0]  st;
      reg  [31:0] cnt;
      wire [1:0]  nw = {sa[2], sb[2]};
      always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          sa  <= 3'h0;
          sb  <= 3'h0;
          st  <= 2'h0;
          cnt <= `ZERO32;
        end else begin
          sa <= {sa[1:0], i_enc_a[e]};
          sb <= {sb[1:0], i_enc_b[e]};
          if (pos_load && (enc_sel == e)) begin
            cnt <= pos_load_val;
          end else if ((sa[2] == sa[1]) && (sb[2] == sb[1]) && (nw != st)) begin
            st <= nw;
            case ({st, nw})
              4'b0001, 4'b0111, 4'b1110, 4'b1000: cnt <= cnt + 32'h0000_0001;
              4'b0010, 4'b1011, 4'b1101, 4'b0100: cnt <= cnt - 32'h0000_0001;
              default: cnt <= cnt;
            endcase
          end
        end
      end
      assign enc_cnt[e] = cnt;
    end
  endgenerate

  // Limiter: peak allowed until the peak timer expires
  wire [31:0] peak_cycles = peak_time * SERVO_PER_MS;
  wire        timed_out   = (peak_cnt >= peak_cycles);
  wire [15:0] lim_time    = timed_out ? cont_lim : peak_lim;
  wire [15:0] lim = (cont_lim < lim_time) && timed_out ? cont_lim : lim_time;
  wire signed [16:0] lim_s = $signed({1'b0, lim});
  wire signed [16:0] cmd_s = $signed({cmd_current[15], cmd_current});
  wire signed [16:0] next_lim_s =
      (cmd_s > lim_s) ? lim_s : ((cmd_s < -lim_s) ? -lim_s : cmd_s);
  wire [16:0] next_abs = next_lim_s[16] ? -next_lim_s : next_lim_s;
  wire [16:0] cmd_abs  = cmd_s[16] ? -cmd_s : cmd_s;
  wire        over_cont = (next_abs > {1'b0, cont_lim}) ||
                          (timed_out && (cmd_abs > {1'b0, cont_lim}));

  // Current loop arithmetic
  wire signed [16:0] cur_err = $signed({limited_current[15], limited_current})
                             - $signed({i_current_actual[15],
                                        i_current_actual});
  wire signed [32:0] integ_sum = $signed({integ[31], integ})
                               + $signed({{16{cur_err[16]}}, cur_err});
  wire [31:0] next_integ = (integ_sum[32] != integ_sum[31]) ?
      (integ_sum[32] ? `S32_MIN : `S32_MAX) : integ_sum[31:0];
  wire signed [33:0] prop_term =
      cur_err * $signed({1'b0, cur_prop_gain});
  wire signed [48:0] int_term =
      $signed(integ) * $signed({1'b0, cur_integral_gain});
  wire signed [49:0] pi_sum = $signed({{16{prop_term[33]}}, prop_term})
                            + $signed({int_term[48], int_term});
  wire signed [49:0] pi_sh  = pi_sum >>> GAIN_SHIFT;
  wire [15:0] loop_cmd = sat16(pi_sh);
  // Offset binary keeps zero command at half duty
  wire [15:0] duty_ofs = {~loop_cmd[15], loop_cmd[14:0]};

  // Feed-forward products
  wire signed [48:0] vff_prod =
      $signed(trajectory_velocity_out) * $signed({1'b0, vel_ff_gain});
  wire signed [48:0] vff_sh = vff_prod >>> `VEL_FF_SHIFT;
  wire [47:0] aff_prod = trajectory_accel_out * acc_ff_gain;
  wire [47:0] aff_sh   = aff_prod >> ACC_FF_SHIFT;

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_d1                 <= 1'b0;
      tick_d2                 <= 1'b0;
      trajectory_velocity_out <= `ZERO32;
      trajectory_accel_out    <= `ZERO32;
      position_demand         <= `ZERO32;
      cmd_current             <= `ZERO16;
      limited_current         <= `ZERO16;
      peak_cnt                <= `ZERO32;
      integ                   <= `ZERO32;
      o_duty                  <= {1'b1, {(PWM_W-1){1'b0}}};
      o_pwm                   <= 1'b0;
      pwm_cnt                 <= {PWM_W{1'b0}};
      o_vel_ff                <= `ZERO32;
      o_accel_ff              <= `ZERO32;
      o_pos_actual            <= `ZERO32;
    end else begin
      tick_d1 <= i_servo_tick;
      tick_d2 <= tick_d1;
      pwm_cnt <= pwm_cnt + {{(PWM_W-1){1'b0}}, 1'b1};
      o_pwm   <= (pwm_cnt < o_duty);
      if (i_servo_tick) begin
        trajectory_velocity_out <= i_traj_vel;
        trajectory_accel_out    <= i_traj_accel;
        position_demand         <= i_traj_pos;
      end
      if (pos_load)
        o_pos_actual <= pos_load_val;
      else if (i_servo_tick)
        o_pos_actual <= enc_cnt[enc_sel];
      if (tick_d1) begin
        cmd_current <= sat16({{18{fout[1][31]}}, fout[1]});
        o_vel_ff    <= sat32({vff_sh[48], vff_sh});
        o_accel_ff  <= (|aff_sh[47:32]) ? 32'hffff_ffff : aff_sh[31:0];
      end
      if (tick_d2) begin
        limited_current <= next_lim_s[15:0];
        if (over_cont)
          peak_cnt <= (&peak_cnt) ? peak_cnt : peak_cnt + 32'h0000_0001;
        else
          peak_cnt <= `ZERO32;
      end
      if (!i_loop_enable) begin
        integ  <= `ZERO32;
        o_duty <= {1'b1, {(PWM_W-1){1'b0}}};
      end else if (i_servo_tick) begin
        integ  <= next_integ;
        o_duty <= duty_ofs[15 -: PWM_W];
      end
    end
  end

  // Object dictionary access
  reg [31:0] rd_val;
  reg        rd_hit;
  reg        wr_ok;
  wire       is_filt = (i_obj_index == `IDX_CMD_FILT) ||
                       (i_obj_index == `IDX_OUT_FILT);
  wire       fsel    = (i_obj_index == `IDX_OUT_FILT);

  always @* begin
    rd_val = `ZERO32;
    rd_hit = 1'b1;
    wr_ok  = 1'b0;
    if (is_filt && (i_obj_sub == `SUB_FILT_TYPE)) begin
      rd_val = {30'h0000_0000, ftype[fsel]};
      wr_ok  = 1'b1;
    end else if (is_filt && (i_obj_sub == `SUB_FILT_B0)) begin
      rd_val = {{16{fb0[fsel][15]}}, fb0[fsel]};
      wr_ok  = 1'b1;
    end else if (is_filt && (i_obj_sub == `SUB_FILT_B1)) begin
      rd_val = {{16{fb1[fsel][15]}}, fb1[fsel]};
      wr_ok  = 1'b1;
    end else if (is_filt && (i_obj_sub == `SUB_FILT_B2)) begin
      rd_val = {{16{fb2[fsel][15]}}, fb2[fsel]};
      wr_ok  = 1'b1;
    end else if (is_filt && (i_obj_sub == `SUB_FILT_A1)) begin
      rd_val = {{16{fa1[fsel][15]}}, fa1[fsel]};
      wr_ok  = 1'b1;
    end else if (is_filt && (i_obj_sub == `SUB_FILT_A2)) begin
      rd_val = {{16{fa2[fsel][15]}}, fa2[fsel]};
      wr_ok  = 1'b1;
    end else if (i_obj_index == `IDX_PEAK_LIM) begin
      rd_val = {`ZERO16, peak_lim};
      wr_ok  = 1'b1;
    end else if (i_obj_index == `IDX_CONT_LIM) begin
      rd_val = {`ZERO16, cont_lim};
      wr_ok  = 1'b1;
    end else if (i_obj_index == `IDX_PEAK_TIME) begin
      rd_val = {`ZERO16, peak_time};
      wr_ok  = 1'b1;
    end else if (i_obj_index == `IDX_CMD_CURRENT) begin
      rd_val = {{16{cmd_current[15]}}, cmd_current};
    end else if (i_obj_index == `IDX_LIM_CURRENT) begin
      rd_val = {{16{limited_current[15]}}, limited_current};
    end else if ((i_obj_index == `IDX_CUR_GAINS) &&
                 (i_obj_sub == `SUB_CUR_PROP)) begin
      rd_val = {`ZERO16, cur_prop_gain};
      wr_ok  = 1'b1;
    end else if ((i_obj_index == `IDX_CUR_GAINS) &&
                 (i_obj_sub == `SUB_CUR_INTEG)) begin
      rd_val = {`ZERO16, cur_integral_gain};
      wr_ok  = 1'b1;
    end else if ((i_obj_index == `IDX_POS_GAINS) &&
                 (i_obj_sub == `SUB_VEL_FF)) begin
      rd_val = {`ZERO16, vel_ff_gain};
      wr_ok  = 1'b1;
    end else if ((i_obj_index == `IDX_POS_GAINS) &&
                 (i_obj_sub == `SUB_ACC_FF)) begin
      rd_val = {`ZERO16, acc_ff_gain};
      wr_ok  = 1'b1;
    end else if (i_obj_index == `IDX_ENC_MOTOR) begin
      rd_val = enc_cnt[0];
    end else if (i_obj_index == `IDX_ENC_LOAD) begin
      rd_val = enc_cnt[1];
    end else if (i_obj_index == `IDX_TRAJ_VEL) begin
      rd_val = trajectory_velocity_out;
    end else if (i_obj_index == `IDX_TRAJ_ACCEL) begin
      rd_val = trajectory_accel_out;
    end else if (i_obj_index == `IDX_POS_DEMAND) begin
      rd_val = position_demand;
    end else if ((i_obj_index == `IDX_POS_ACTUAL) ||
                 (i_obj_index == `IDX_POS_ALIAS)) begin
      rd_val = o_pos_actual;
      wr_ok  = 1'b1;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_obj_rdata       <= `ZERO32;
      o_obj_ack         <= 1'b0;
      o_obj_err         <= 1'b0;
      pos_load          <= 1'b0;
      pos_load_val      <= `ZERO32;
      ftype[0]          <= `FT_OFF;
      ftype[1]          <= `FT_OFF;
      fb0[0]            <= `RST_COEF;
      fb0[1]            <= `RST_COEF;
      fb1[0]            <= `RST_COEF;
      fb1[1]            <= `RST_COEF;
      fb2[0]            <= `RST_COEF;
      fb2[1]            <= `RST_COEF;
      fa1[0]            <= `RST_COEF;
      fa1[1]            <= `RST_COEF;
      fa2[0]            <= `RST_COEF;
      fa2[1]            <= `RST_COEF;
      peak_lim          <= `RST_LIMIT;
      cont_lim          <= `RST_LIMIT;
      peak_time         <= `RST_LIMIT;
      cur_prop_gain     <= `RST_GAIN;
      cur_integral_gain <= `RST_GAIN;
      vel_ff_gain       <= `RST_GAIN;
      acc_ff_gain       <= `RST_GAIN;
    end else begin
      o_obj_ack <= (i_obj_rd || i_obj_wr) && rd_hit && !(i_obj_wr && !wr_ok);
      o_obj_err <= (i_obj_rd || i_obj_wr) && (!rd_hit || (i_obj_wr && !wr_ok));
      pos_load  <= 1'b0;
      if (i_obj_rd && !i_obj_wr)
        o_obj_rdata <= rd_val;
      if (i_obj_wr && wr_ok) begin
        if (is_filt && (i_obj_sub == `SUB_FILT_TYPE))
          ftype[fsel] <= i_obj_wdata[1:0];
        else if (is_filt && (i_obj_sub == `SUB_FILT_B0))
          fb0[fsel] <= i_obj_wdata[15:0];
        else if (is_filt && (i_obj_sub == `SUB_FILT_B1))
          fb1[fsel] <= i_obj_wdata[15:0];
        else if (is_filt && (i_obj_sub == `SUB_FILT_B2))
          fb2[fsel] <= i_obj_wdata[15:0];
        else if (is_filt && (i_obj_sub == `SUB_FILT_A1))
          fa1[fsel] <= i_obj_wdata[15:0];
        else if (is_filt && (i_obj_sub == `SUB_FILT_A2))
          fa2[fsel] <= i_obj_wdata[15:0];
        else if (i_obj_index == `IDX_PEAK_LIM)
          peak_lim <= (i_obj_wdata[15:0] > RATED_PEAK) ?
                      RATED_PEAK : i_obj_wdata[15:0];
        else if (i_obj_index == `IDX_CONT_LIM)
          cont_lim <= i_obj_wdata[15:0];
        else if (i_obj_index == `IDX_PEAK_TIME)
          peak_time <= i_obj_wdata[15:0];
        else if (i_obj_index == `IDX_CUR_GAINS &&
                 i_obj_sub == `SUB_CUR_PROP)
          cur_prop_gain <= i_obj_wdata[15:0];
        else if (i_obj_index == `IDX_CUR_GAINS)
          cur_integral_gain <= i_obj_wdata[15:0];
        else if (i_obj_sub == `SUB_VEL_FF && i_obj_index == `IDX_POS_GAINS)
          vel_ff_gain <= i_obj_wdata[15:0];
        else if (i_obj_index == `IDX_POS_GAINS)
          acc_ff_gain <= i_obj_wdata[15:0];
        else begin
          // Preset lands in the active encoder so both aliases agree
          pos_load     <= 1'b1;
          pos_load_val <= i_obj_wdata;
        end
      end
    end
  end

endmodule // servo_current_loop

// ===== servo_loop_map.vh
// Object indices, sub-indices, field codes and reset values of the servo loop
`ifndef SERVO_LOOP_MAP_VH
`define SERVO_LOOP_MAP_VH

`define IDX_OUT_FILT      16'h2106
`define IDX_CMD_FILT      16'h2108
`define IDX_PEAK_LIM      16'h2110
`define IDX_CONT_LIM      16'h2111
`define IDX_PEAK_TIME     16'h2112
`define IDX_CMD_CURRENT   16'h221D
`define IDX_LIM_CURRENT   16'h221E
`define IDX_ENC_MOTOR     16'h2240
`define IDX_ENC_LOAD      16'h2242
`define IDX_TRAJ_VEL      16'h2250
`define IDX_TRAJ_ACCEL    16'h2251
`define IDX_CUR_GAINS     16'h2380
`define IDX_POS_GAINS     16'h2382
`define IDX_POS_DEMAND    16'h6062
`define IDX_POS_ACTUAL    16'h6063
`define IDX_POS_ALIAS     16'h6064

`define SUB_VALUE         8'h00
`define SUB_FILT_TYPE     8'h01
`define SUB_FILT_B0       8'h02
`define SUB_FILT_B1       8'h03
`define SUB_FILT_B2       8'h04
`define SUB_FILT_A1       8'h05
`define SUB_FILT_A2       8'h06
`define SUB_CUR_PROP      8'h01
`define SUB_CUR_INTEG     8'h02
`define SUB_VEL_FF        8'h02
`define SUB_ACC_FF        8'h03

`define FT_OFF            2'h0
`define FT_SINGLE         2'h1
`define FT_BUTTER         2'h2
`define FT_BIQUAD         2'h3

`define COEF_SHIFT        14
`define VEL_FF_SHIFT      14

`define RST_LIMIT         16'h0000
`define RST_GAIN          16'h0000
`define RST_COEF          16'h0000
`define ZERO16            16'h0000
`define ZERO32            32'h0000_0000
`define S32_MAX           32'h7fff_ffff
`define S32_MIN           32'h8000_0000
`define S16_MAX           16'h7fff
`define S16_MIN           16'h8000

`endif

// ===== servo_loop_props_properties.sv
// Port checker of the servo current loop, bound to the block
`timescale 1ns/10ps
`include "servo_loop_map.vh"
module servo_loop_props #(
  parameter PWM_W = 12
) (
  input wire             i_clk,
  input wire             i_nrst,
  input wire             i_servo_tick,
  input wire             i_loop_enable,
  input wire             i_obj_rd,
  input wire             i_obj_wr,
  input wire [15:0]      i_obj_index,
  input wire [31:0]      i_obj_wdata,
  input wire [31:0]      o_obj_rdata,
  input wire             o_obj_ack,
  input wire             o_obj_err,
  input wire [31:0]      o_vel_ff,
  input wire [31:0]      o_accel_ff,
  input wire [31:0]      o_pos_actual,
  input wire [PWM_W-1:0] o_duty
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  wire obj_req = i_obj_rd | i_obj_wr;
  sequence wr_at(idx);
    i_obj_wr && i_obj_index == idx;
  endsequence
  // Disabled loop seen on a servo tick; chk_idle_duty adds the hold-off
  sequence idle_tick;
    !i_loop_enable && i_servo_tick;
  endsequence
  chk_one_answer: assert property (obj_req |=> o_obj_ack != o_obj_err)
    else $error("Object request without a single answer");
  chk_no_stray: assert property (!obj_req |=> !o_obj_ack && !o_obj_err)
    else $error("Answer without object request");
  chk_vel_ro: assert property (wr_at(`IDX_TRAJ_VEL) |=> o_obj_err)
    else $error("Write to trajectory velocity accepted");
  chk_accel_ro: assert property (wr_at(`IDX_TRAJ_ACCEL) |=> o_obj_err)
    else $error("Write to trajectory acceleration accepted");
  chk_demand_ro: assert property (wr_at(`IDX_POS_DEMAND) |=> o_obj_err)
    else $error("Write to position demand accepted");
  chk_pos_preset: assert property (wr_at(`IDX_POS_ACTUAL) |->
    ##2 o_pos_actual == $past(i_obj_wdata, 2))
    else $error("Actual position not preset by write");
  chk_alias_read: assert property (i_obj_rd &&
    i_obj_index == `IDX_POS_ALIAS |=> o_obj_rdata == $past(o_pos_actual))
    else $error("Alias read differs from actual position");
  chk_idle_duty: assert property (idle_tick ##1 (!i_loop_enable)[*2] |->
    o_duty == {1'b1, {(PWM_W-1){1'b0}}})
    else $error("Duty not at half scale while loop disabled");
  chk_ff_hold: assert property ((!i_servo_tick)[*4] |->
    $stable(o_vel_ff) && $stable(o_accel_ff))
    else $error("Feed-forward moved between servo ticks");
endmodule // servo_loop_props
bind servo_current_loop servo_loop_props #(.PWM_W(PWM_W)) i_props (.*);

// ===== power_stage_model.sv
// Power stage and quadrature encoder model for the servo loop bench
`timescale 1ns/10ps
module power_stage_model (
  input  wire        i_clk,
  input  wire [1:0]  i_step,
  input  wire        i_dir,
  input  wire        i_stage_on,
  input  wire [11:0] i_duty,
  output wire [1:0]  o_enc_a,
  output wire [1:0]  o_enc_b,
  output wire [15:0] o_current
);
  reg [1:0] ph0 = 2'h0;
  reg [1:0] ph1 = 2'h0;
  // Gray order 00, 01, 11, 10 on (a, b) counts up
  assign o_enc_a = {ph1[1], ph0[1]};
  assign o_enc_b = {ph1[1] ^ ph1[0], ph0[1] ^ ph0[0]};
  // Ideal stage without inductance; no current while switched off
  assign o_current = i_stage_on ? {4'h0, i_duty} - 16'h0800 : 16'h0000;
  always @(posedge i_clk) begin
    if (i_step[0]) ph0 <= i_dir ? ph0 + 2'h1 : ph0 - 2'h1;
    if (i_step[1]) ph1 <= i_dir ? ph1 + 2'h1 : ph1 - 2'h1;
  end
endmodule // power_stage_model

// ===== tb_servo_current_loop.sv
// Self-checking bench of the servo current loop block
`timescale 1ns/10ps
`include "servo_loop_map.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  err_total++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_servo_current_loop;
  localparam [33:0] WOK = 34'h0_0000_0000;
  localparam [33:0] BAD = 34'h1_0000_0000;
  reg         i_clk = 0, i_nrst = 0, i_servo_tick = 0, i_loop_enable = 0;
  reg         i_dual_encoder = 0, i_obj_rd = 0, i_obj_wr = 0, dir = 0;
  reg  [31:0] i_vel_cmd = 0, i_traj_pos = 0, i_traj_vel = 0, r, ev;
  reg  [31:0] i_traj_accel = 0, i_obj_wdata = 0;
  reg  [15:0] i_vel_loop_out = 0, i_obj_index = 0;
  reg  [7:0]  i_obj_sub = 0;
  reg  [1:0]  step = 0;
  reg         stage_on = 0;
  reg  [11:0] d1;
  reg  [33:0] note;
  reg  [33:0] q[$];
  reg  [15:0] ro_idx [0:6] = '{`IDX_CMD_CURRENT, `IDX_LIM_CURRENT,
    `IDX_ENC_MOTOR, `IDX_ENC_LOAD, `IDX_TRAJ_VEL, `IDX_TRAJ_ACCEL,
    `IDX_POS_DEMAND};
  wire [31:0] o_obj_rdata, o_vel_cmd_filt, o_vel_ff, o_accel_ff, o_pos_actual;
  wire [15:0] i_current_actual;
  wire [1:0]  i_enc_a, i_enc_b;
  wire [11:0] o_duty;
  wire        o_obj_ack, o_obj_err, o_pwm;
  int         err_total = 0, total_checks = 0, hi;
  always #10 i_clk = ~i_clk;
  servo_current_loop #(.RATED_PEAK(16'h1000), .SERVO_PER_MS(16'h0002))
    i_dut (.*);
  power_stage_model i_model (.i_clk(i_clk), .i_step(step), .i_dir(dir),
    .i_stage_on(stage_on), .i_duty(o_duty), .o_enc_a(i_enc_a),
    .o_enc_b(i_enc_b), .o_current(i_current_actual));
  function [33:0] rv(input [31:0] v);
    rv = {2'b10, v};
  endfunction
  task final_report;
    $display("Checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task obj(input w, input [15:0] x, input [7:0] s, input [31:0] d,
           input [33:0] e);
    @(negedge i_clk);
    {i_obj_wr, i_obj_rd, i_obj_index, i_obj_sub, i_obj_wdata} = {w, !w, x, s, d};
    q.push_back(e);
    @(negedge i_clk);
    {i_obj_wr, i_obj_rd} = 2'b00;
  endtask
  task tick(input integer n);
    repeat (n) begin
      @(negedge i_clk) i_servo_tick = 1;
      @(negedge i_clk) i_servo_tick = 0;
      repeat (4) @(negedge i_clk);
    end
  endtask
  // Steps spaced well past the pin synchronizer depth
  task move(input ch, input up, input integer n);
    repeat (n) begin
      @(negedge i_clk) {dir, step[ch]} = {up, 1'b1};
      @(negedge i_clk) step[ch] = 0;
      repeat (8) @(negedge i_clk);
    end
  endtask
  always @(negedge i_clk) if (o_obj_ack === 1'b1 || o_obj_err === 1'b1) begin
    note = q.pop_front();
    `CHK("obj_err", note[32], o_obj_err)
    if (note[33]) `CHK("obj_rdata", note[31:0], o_obj_rdata)
  end
  initial begin
    #400_000;
    err_total++;
    final_report;
  end
  initial begin
    r = $urandom(32'hb1020e22);
    repeat (2) @(negedge i_clk);
    i_nrst = 1;
    `CHK("duty_reset", 12'h800, o_duty)
    obj(0, `IDX_PEAK_LIM, 0, 0, rv(0));
    $display("Test reset done");
    obj(1, `IDX_PEAK_LIM, 0, 32'h2000, WOK);
    obj(0, `IDX_PEAK_LIM, 0, 0, rv(32'h1000));
    obj(1, `IDX_CONT_LIM, 0, 32'h0800, WOK);
    obj(0, `IDX_CONT_LIM, 0, 0, rv(32'h0800));
    obj(1, `IDX_PEAK_TIME, 0, 32'h0001, WOK);
    obj(1, `IDX_CUR_GAINS, 8'h03, 1, BAD);
    obj(0, 16'h1234, 0, 0, BAD);
    for (int i = 0; i < 7; i++) obj(1, ro_idx[i], 0, 1, BAD);
    $display("Test registers done");
    i_vel_loop_out = 16'h3000;
    tick(1);
    obj(0, `IDX_CMD_CURRENT, 0, 0, rv(32'h3000));
    obj(0, `IDX_LIM_CURRENT, 0, 0, rv(32'h1000));
    tick(6);
    obj(0, `IDX_LIM_CURRENT, 0, 0, rv(32'h0800));
    i_vel_loop_out = 16'h0400;
    tick(1);
    obj(0, `IDX_LIM_CURRENT, 0, 0, rv(32'h0400));
    i_vel_loop_out = 16'h3000;
    tick(1);
    obj(0, `IDX_LIM_CURRENT, 0, 0, rv(32'h1000));
    $display("Test limiter done");
    i_traj_pos = $urandom;
    r = $urandom;
    i_traj_vel = {{12{r[19]}}, r[19:0]};
    i_traj_accel = $urandom & 32'h000f_ffff;
    for (int k = 0; k < 3; k++) begin
      obj(1, `IDX_POS_GAINS, `SUB_VEL_FF, 32'h4000 >> k, WOK);
      obj(1, `IDX_POS_GAINS, `SUB_ACC_FF, 32'h4000 >> k, WOK);
      tick(1);
      ev = $signed(i_traj_vel) >>> k;
      `CHK("vel_ff", ev, o_vel_ff)
      `CHK("accel_ff", i_traj_accel >> k, o_accel_ff)
    end
    obj(0, `IDX_TRAJ_VEL, 0, 0, rv(i_traj_vel));
    obj(0, `IDX_TRAJ_ACCEL, 0, 0, rv(i_traj_accel));
    obj(0, `IDX_POS_DEMAND, 0, 0, rv(i_traj_pos));
    $display("Test trajectory done");
    for (int t = 1; t < 4; t++) begin
      obj(1, `IDX_CMD_FILT, `SUB_FILT_TYPE, t, WOK);
      obj(1, `IDX_CMD_FILT, `SUB_FILT_B0, 32'h2000, WOK);
      obj(1, `IDX_CMD_FILT, `SUB_FILT_B1, 32'h2000, WOK);
      obj(1, `IDX_CMD_FILT, `SUB_FILT_A1, 32'he000, WOK);
      obj(0, `IDX_CMD_FILT, `SUB_FILT_A1, 0, rv(32'hffff_e000));
      i_vel_cmd = 0;
      tick(16);
      i_vel_cmd = 32'h1000;
      tick(1);
      `CHK("filt_first", 32'h0800, o_vel_cmd_filt)
      tick(1);
      `CHK("filt_second", 32'h1400, o_vel_cmd_filt)
    end
    obj(1, `IDX_OUT_FILT, `SUB_FILT_TYPE, 3, WOK);
    obj(1, `IDX_OUT_FILT, `SUB_FILT_B0, 32'h2000, WOK);
    i_vel_loop_out = 16'h0400;
    tick(1);
    obj(0, `IDX_CMD_CURRENT, 0, 0, rv(32'h0200));
    $display("Test filters done");
    r = $urandom;
    obj(1, `IDX_POS_ACTUAL, 0, r, WOK);
    obj(0, `IDX_POS_ALIAS, 0, 0, rv(r));
    move(0, 1, 4);
    tick(1);
    obj(0, `IDX_POS_ACTUAL, 0, 0, rv(r + 4));
    i_dual_encoder = 1;
    move(1, 0, 3);
    tick(1);
    obj(0, `IDX_POS_ALIAS, 0, 0, rv(32'hffff_fffd));
    obj(0, `IDX_ENC_LOAD, 0, 0, rv(32'hffff_fffd));
    $display("Test position done");
    obj(1, `IDX_CUR_GAINS, `SUB_CUR_PROP, 32'h4000, WOK);
    obj(1, `IDX_CUR_GAINS, `SUB_CUR_INTEG, 0, WOK);
    i_loop_enable = 1;
    tick(2);
    d1 = o_duty;
    `CHK("duty_pos", 1'b1, d1 > 12'h800)
    tick(2);
    `CHK("duty_p_only", d1, o_duty)
    hi = 0;
    repeat (4096) @(negedge i_clk) hi += o_pwm;
    `CHK("pwm_high", d1, hi[11:0])
    obj(1, `IDX_CUR_GAINS, `SUB_CUR_PROP, 0, WOK);
    obj(1, `IDX_CUR_GAINS, `SUB_CUR_INTEG, 32'h1000, WOK);
    tick(2);
    d1 = o_duty;
    tick(2);
    `CHK("duty_integ", 1'b1, o_duty > d1)
    d1 = o_duty;
    i_loop_enable = 0;
    tick(1);
    `CHK("duty_off", 12'h800, o_duty)
    i_loop_enable = 1;
    tick(1);
    `CHK("integ_clear", 1'b1, o_duty < d1)
    obj(1, `IDX_CUR_GAINS, `SUB_CUR_PROP, 32'h4000, WOK);
    obj(1, `IDX_CUR_GAINS, `SUB_CUR_INTEG, 0, WOK);
    i_vel_loop_out = 16'hfc00;
    stage_on = 1;
    tick(3);
    `CHK("duty_neg", 1'b1, o_duty < 12'h800)
    $display("Test current loop done");
    repeat (2) @(negedge i_clk);
    `CHK("pending_answers", 0, q.size())
    final_report;
  end
endmodule // tb_servo_current_loop
